/* ssd_pkg.sv */
// Purpose: Shared constants and types for the serial link register block
// Assumes: 10 MHz sys_clk, Avalon-MM byte addresses
// Notes:   Register byte address is four times the register index
package ssd_pkg;
  // Register indices and their byte addresses
  localparam logic [7:0] IDX_DBG    = 8'h08;
  localparam logic [7:0] IDX_BAUD   = 8'h0A;
  localparam logic [7:0] IDX_IENCLR = 8'h0C;
  localparam logic [7:0] IDX_IENSET = 8'h0D;
  localparam logic [7:0] IDX_FLAGS  = 8'h0E;
  localparam logic [7:0] IDX_STATUS = 8'h10;
  localparam logic [7:0] IDX_ADDR   = 8'h14;
  localparam logic [7:0] IDX_DATA   = 8'h18;
  localparam logic [7:0] IDX_CTRL   = 8'h1C;
  localparam logic [7:0] ADR_DBG    = 8'h20;
  localparam logic [7:0] ADR_BAUD   = 8'h28;
  localparam logic [7:0] ADR_IENCLR = 8'h30;
  localparam logic [7:0] ADR_IENSET = 8'h34;
  localparam logic [7:0] ADR_FLAGS  = 8'h38;
  localparam logic [7:0] ADR_STATUS = 8'h40;
  localparam logic [7:0] ADR_ADDR   = 8'h50;
  localparam logic [7:0] ADR_DATA   = 8'h60;
  localparam logic [7:0] ADR_CTRL   = 8'h70;
  // Field positions
  localparam int DBG_STOP    = 0;
  localparam int FLAG_RXC    = 2;
  localparam int FLAG_TXC    = 1;
  localparam int FLAG_DRE    = 0;
  localparam int STAT_SYNC   = 15;
  localparam int STAT_OVF    = 2;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_HOST   = 1;
  localparam int CTRL_FRAME_FORMAT_SELECT   = 2;
  localparam int CTRL_IMMEDIATE_OVERFLOW_NOTIFY   = 8;
  localparam int CTRL_CLIENT_MATCH_METHOD  = 14;
  localparam int CTRL_RECEIVER_ON   = 17;
  // Writable bit masks and reset values
  localparam logic [31:0] CTRL_WMASK = 32'h0002C107;
  localparam logic [31:0] ADDR_WMASK = 32'h00FF00FF;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] ADDR_RESET = 32'h00000000;
  localparam logic [7:0]  BAUD_RESET = 8'h00;
  localparam logic [2:0]  IEN_RESET  = 3'h0;
  // Domain transfer time after a control write
  localparam int CLK_PERIOD_NS = 100;
  localparam int SYNC_TIME_NS  = 300;
  localparam logic [2:0] SYNC_CYCLES =
    3'((SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Receive buffer depth
  localparam int RXBUF_DEPTH = 2;
  localparam logic [1:0] RXBUF_FULL = 2'h2;
  // Client match methods
  typedef enum logic [1:0] {
    MATCH_MASK  = 2'h0,
    MATCH_TWO   = 2'h1,
    MATCH_RANGE = 2'h2
  } ssd_match_type;
  // Bus answer states
  typedef enum logic {
    BUS_HOLD   = 1'b0,
    BUS_ANSWER = 1'b1
  } ssd_bus_type;
  // One receive buffer entry
  typedef struct packed {
    logic       ovf;
    logic [8:0] word;
  } ssd_rxent_type;
  // Character handed over by the shift engine
  typedef struct packed {
    logic       push;
    logic       addrPhase;
    logic [8:0] word;
  } ssd_rxin_type;
endpackage

/* ssd_regs.sv */
// Purpose: Register side of a serial peripheral link unit, host or client
// Assumes: Shift engine outside; single 10 MHz clock; Avalon-MM slave
// Notes:   Every access answers after one wait cycle
`timescale 1ns/10ps
`default_nettype none
module ssd_regs
  import ssd_pkg::*;
(
  input  wire logic         sys_clk,          // System clock
  input  wire logic         resetn,           // Async reset, low active
  input  wire logic [7:0]   avs_address,      // Byte address
  input  wire logic         avs_read,         // Read request
  input  wire logic         avs_write,        // Write request
  input  wire logic [3:0]   avs_byteenable,   // Write byte lanes
  input  wire logic [31:0]  avs_writedata,    // Write data
  output logic [31:0]       avs_readdata,     // Read data
  output logic              avs_waitrequest,  // Stall request
  input  wire ssd_rxin_type rxIn,             // Received character
  input  wire logic         txTake,           // Engine takes tx word
  input  wire logic         shiftDone,        // Shifter emptied
  input  wire logic         selectHigh,       // Select line level
  input  wire logic         debugHalt,        // CPU halted by debugger
  output logic [8:0]        txWord,           // Word to transmit
  output logic              txValid,          // Tx word waiting
  output logic              rateTick,         // Bit-rate pulse
  output logic              irqReq,           // Interrupt request
  output logic              linkEnable,       // Unit enabled
  output logic              hostMode          // Host operation
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Merge write data into a register by byte lanes and writable mask
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be,
                                        input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old & ~m) | (nw & m);
  endfunction

  // Address match against the client match settings
  function automatic logic addrMatch(input logic [7:0] rx,
                                     input logic [31:0] a,
                                     input logic [1:0] method);
    logic [7:0] adr;
    logic [7:0] msk;
    adr = a[7:0];
    msk = a[23:16];
    case (method)
      MATCH_MASK:  return ((rx ^ adr) & ~msk) == 8'h00;
      MATCH_TWO:   return (rx == adr) || (rx == msk);
      MATCH_RANGE: return (rx >= msk) && (rx <= adr);
      default:     return 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  ssd_bus_type   busSt_r;         // Bus answer state
  logic          waitReq_r;       // Waitrequest flop
  logic [31:0]   rdData_r;        // Read data flop
  logic          popOk_r;         // Captured read had data
  logic          freeze_on_debug_halt_r;       // Freeze on debug halt
  logic [7:0]    baud_r;          // Bit-rate divider
  logic [2:0]    ien_r;           // Shared interrupt enables
  logic [31:0]   ctrl_r;          // Control word
  logic [31:0]   addr_r;          // Match address and mask
  logic [2:0]    syncCnt_r;       // Domain transfer countdown
  logic [7:0]    rateCnt_r;       // Bit-rate countdown
  logic          rateTick_r;      // Bit-rate pulse
  ssd_rxent_type rxMem [RXBUF_DEPTH]; // Receive buffer
  logic          rxWp_r;          // Write pointer
  logic          rxRp_r;          // Read pointer
  logic [1:0]    rxCnt_r;         // Entries held
  logic          ovfPend_r;       // Overflow to tag on next entry
  logic          ovf_r;           // Overflow status
  logic          headTag_r;       // Previous head-tagged state
  logic          txnMatch_r;      // Transaction began with match
  logic [8:0]    txWord_r;        // Transmit data register
  logic          txFull_r;        // Transmit data waiting
  logic          txc_r;           // Transmit complete flag
  logic          selHigh_r;       // Previous select level
  logic          irq_r;           // Interrupt request flop
  logic [31:0]   rdMux;           // Read mux
  logic          req;
  logic          done;
  logic          wrDone;
  logic          rdDone;

  assign req    = avs_read | avs_write;
  assign done   = req && (busSt_r == BUS_ANSWER);
  assign wrDone = avs_write && done;
  assign rdDone = avs_read && done;

  // Decoded control fields
  logic enable;
  logic rxOn;
  logic addrFmt;
  logic immediate_overflow_notify;
  assign enable  = ctrl_r[CTRL_ENABLE];
  assign rxOn    = ctrl_r[CTRL_RECEIVER_ON];
  assign addrFmt = ctrl_r[CTRL_FRAME_FORMAT_SELECT] && !ctrl_r[CTRL_HOST];
  assign immediate_overflow_notify    = ctrl_r[CTRL_IMMEDIATE_OVERFLOW_NOTIFY];

  // Write strobes per register, and the data read strobe
  logic wrDbg, wrBaud, wrIenClr, wrIenSet, wrFlags;
  logic wrStatus, wrAddr, wrData, wrCtrl, rdData;
  assign wrDbg    = wrDone && (avs_address == ADR_DBG);
  assign wrBaud   = wrDone && (avs_address == ADR_BAUD);
  assign wrIenClr = wrDone && (avs_address == ADR_IENCLR);
  assign wrIenSet = wrDone && (avs_address == ADR_IENSET);
  assign wrFlags  = wrDone && (avs_address == ADR_FLAGS) && avs_byteenable[0];
  assign wrStatus = wrDone && (avs_address == ADR_STATUS) && avs_byteenable[0];
  assign wrAddr   = wrDone && (avs_address == ADR_ADDR);
  assign wrData   = wrDone && (avs_address == ADR_DATA) && (|avs_byteenable[1:0]);
  assign wrCtrl   = wrDone && (avs_address == ADR_CTRL);
  assign rdData   = rdDone && (avs_address == ADR_DATA);

  // Receive side status, and the transmit buffer empty flag
  ssd_rxent_type head;
  logic headValid;
  logic headTag;
  logic receive_complete;
  logic transmit_buffer_empty;
  assign head      = rxMem[rxRp_r];
  assign headValid = rxCnt_r != 2'h0;
  assign headTag   = headValid && head.ovf;
  assign receive_complete       = headValid;
  assign transmit_buffer_empty       = !txFull_r;

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: one wait cycle, then complete

  // Read data is captured on the first edge so it stands at completion
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      busSt_r   <= BUS_HOLD;
      waitReq_r <= 1'b1;
      rdData_r  <= 32'h00000000;
      popOk_r   <= 1'b0;
    end
    else if (busSt_r == BUS_HOLD && req)
    begin
      busSt_r   <= BUS_ANSWER;
      waitReq_r <= 1'b0;
      rdData_r  <= rdMux;
      popOk_r   <= avs_read && (avs_address == ADR_DATA) && headValid;
    end
    else
    begin
      busSt_r   <= BUS_HOLD;
      waitReq_r <= 1'b1;
      popOk_r   <= 1'b0;
    end
  end

  // Read mux; unmapped addresses and reserved bits read zero
  always_comb
  begin
    rdMux = 32'h00000000;
    case (avs_address)
      ADR_DBG:    rdMux[DBG_STOP] = freeze_on_debug_halt_r;
      ADR_BAUD:   rdMux[7:0] = baud_r;
      ADR_IENCLR: rdMux[2:0] = ien_r;
      ADR_IENSET: rdMux[2:0] = ien_r;
      ADR_FLAGS:  rdMux[2:0] = {receive_complete, txc_r, transmit_buffer_empty};
      ADR_STATUS:
      begin
        rdMux[STAT_SYNC] = syncCnt_r != 3'h0;
        rdMux[STAT_OVF]  = ovf_r;
      end
      ADR_ADDR:   rdMux = addr_r;
      ADR_DATA:   rdMux[8:0] = headValid ? head.word : 9'h000;
      ADR_CTRL:   rdMux = ctrl_r;
      default:    rdMux = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Debug control is not enable-protected
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      freeze_on_debug_halt_r <= 1'b0;
    else if (wrDbg && avs_byteenable[0])
      freeze_on_debug_halt_r <= avs_writedata[DBG_STOP];
  end

  // Divider and match address only change while the unit is off
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      baud_r <= BAUD_RESET;
      addr_r <= ADDR_RESET;
    end
    else if (!enable)
    begin
      if (wrBaud && avs_byteenable[0])
        baud_r <= avs_writedata[7:0];
      if (wrAddr)
        addr_r <= merge(addr_r, avs_writedata, avs_byteenable, ADDR_WMASK);
    end
  end

  // Control word; each write starts a domain transfer
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_r    <= CTRL_RESET;
      syncCnt_r <= 3'h0;
    end
    else if (wrCtrl)
    begin
      ctrl_r    <= merge(ctrl_r, avs_writedata, avs_byteenable, CTRL_WMASK);
      syncCnt_r <= SYNC_CYCLES;
    end
    else if (syncCnt_r != 3'h0)
      syncCnt_r <= syncCnt_r - 3'h1;
  end

  // One enable state seen through two write views
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      ien_r <= IEN_RESET;
    else if (wrIenClr && avs_byteenable[0])
      ien_r <= ien_r & ~avs_writedata[2:0];
    else if (wrIenSet && avs_byteenable[0])
      ien_r <= ien_r | avs_writedata[2:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit-rate generator: one tick every divider+1 cycles

  // Holding the count keeps the phase across a debug halt
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rateCnt_r  <= 8'h00;
      rateTick_r <= 1'b0;
    end
    else if (!enable)
    begin
      rateCnt_r  <= baud_r;
      rateTick_r <= 1'b0;
    end
    else if (freeze_on_debug_halt_r && debugHalt)
      rateTick_r <= 1'b0;
    else if (rateCnt_r == 8'h00)
    begin
      rateCnt_r  <= baud_r;
      rateTick_r <= 1'b1;
    end
    else
    begin
      rateCnt_r  <= rateCnt_r - 8'h01;
      rateTick_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive path

  logic accept;
  logic isMatch;
  logic keep;
  logic pop;
  logic full;
  logic overflow;
  logic store;
  logic selRise;
  assign selRise  = selectHigh && !selHigh_r;
  assign isMatch  = addrMatch(rxIn.word[7:0], addr_r, ctrl_r[CTRL_CLIENT_MATCH_METHOD +: 2]);
  assign keep     = !addrFmt || (rxIn.addrPhase ? isMatch : txnMatch_r);
  assign accept   = rxIn.push && enable && rxOn && keep;
  assign pop      = rdData && popOk_r;
  assign full     = rxCnt_r == RXBUF_FULL;
  assign overflow = accept && full && !pop;
  assign store    = accept && (!full || pop);

  // Match state of the current client transaction
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      txnMatch_r <= 1'b0;
      selHigh_r  <= 1'b1;
    end
    else
    begin
      selHigh_r <= selectHigh;
      if (rxIn.push && rxIn.addrPhase)
        txnMatch_r <= isMatch;
      else if (selRise)
        txnMatch_r <= 1'b0;
    end
  end

  // Buffer storage; an overflow tags the next stored entry with zero data
  always_ff @(posedge sys_clk)
  begin
    if (store)
    begin
      rxMem[rxWp_r].ovf  <= ovfPend_r || overflow;
      rxMem[rxWp_r].word <= (ovfPend_r || overflow) ? 9'h000 : rxIn.word;
    end
  end

  // Pointers and count; receiver off flushes at once
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rxWp_r  <= 1'b0;
      rxRp_r  <= 1'b0;
      rxCnt_r <= 2'h0;
    end
    else if (!rxOn)
    begin
      rxWp_r  <= 1'b0;
      rxRp_r  <= 1'b0;
      rxCnt_r <= 2'h0;
    end
    else
    begin
      if (store)
        rxWp_r <= ~rxWp_r;
      if (pop)
        rxRp_r <= ~rxRp_r;
      if (store && !pop)
        rxCnt_r <= rxCnt_r + 2'h1;
      else if (pop && !store)
        rxCnt_r <= rxCnt_r - 2'h1;
    end
  end

  // Overflow status: immediate, or when the tagged entry reaches the head
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ovfPend_r <= 1'b0;
      ovf_r     <= 1'b0;
      headTag_r <= 1'b0;
    end
    else if (!rxOn)
    begin
      ovfPend_r <= 1'b0;
      ovf_r     <= 1'b0;
      headTag_r <= 1'b0;
    end
    else
    begin
      headTag_r <= headTag;
      if (overflow && !store)
        ovfPend_r <= 1'b1;
      else if (store)
        ovfPend_r <= 1'b0;
      // Set wins over a write-one clear in the same cycle
      if (immediate_overflow_notify ? overflow : (headTag && !headTag_r))
        ovf_r <= 1'b1;
      else if (wrStatus && avs_writedata[STAT_OVF])
        ovf_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path

  // Lane merge of a data write; only the low nine bits are kept
  logic [31:0] txMerged;
  assign txMerged = merge({23'h0, txWord_r}, avs_writedata, avs_byteenable, 32'h000001FF);

  // Single data register between software and the shifter
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      txWord_r <= 9'h000;
      txFull_r <= 1'b0;
    end
    else if (wrData)
    begin
      txWord_r <= txMerged[8:0];
      txFull_r <= 1'b1;
    end
    else if (txTake)
      txFull_r <= 1'b0;
  end

  // Transmit complete; a set in the clearing cycle wins, except a host set during a data write
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      txc_r <= 1'b0;
    else if (enable && ctrl_r[CTRL_HOST] && shiftDone && !txFull_r && !wrData)
      txc_r <= 1'b1;
    else if (enable && !ctrl_r[CTRL_HOST] && selRise && (!addrFmt || txnMatch_r))
      txc_r <= 1'b1;
    else if (wrData || (wrFlags && avs_writedata[FLAG_TXC]))
      txc_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request

  // Level while any enabled flag stands
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      irq_r <= 1'b0;
    else
      irq_r <= |({receive_complete, txc_r, transmit_buffer_empty} & ien_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops

  assign avs_readdata    = rdData_r;
  assign avs_waitrequest = waitReq_r;
  assign txWord          = txWord_r;
  assign txValid         = txFull_r;
  assign rateTick        = rateTick_r;
  assign irqReq          = irq_r;
  assign linkEnable      = ctrl_r[CTRL_ENABLE];
  assign hostMode        = ctrl_r[CTRL_HOST];

endmodule
`default_nettype wire

/* ssd_regs_asserts.sv */
// Purpose: Port checks for the serial link register block
// Assumes: One clock, async low reset
// Notes:   Bound to every ssd_regs instance
`timescale 1ns/10ps
`default_nettype none
module ssd_regs_asserts
  import ssd_pkg::*;
(
  input  wire logic        sys_clk,          // Clock
  input  wire logic        resetn,           // Reset, low active
  input  wire logic [7:0]  avs_address,      // Byte address
  input  wire logic        avs_read,         // Read request
  input  wire logic        avs_write,        // Write request
  input  wire logic [31:0] avs_writedata,    // Write data
  input  wire logic [31:0] avs_readdata,     // Read data
  input  wire logic        avs_waitrequest,  // Stall
  input  wire logic        txTake,           // Engine takes word
  input  wire logic [8:0]  txWord,           // Word to send
  input  wire logic        txValid,          // Word waiting
  input  wire logic        irqReq            // Interrupt
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  //////////////////////////////
  // Completed accesses, decoded once so the properties stay short
  logic wrData;  // Data word written at this edge
  logic enOff;   // All enables cleared at this edge
  logic rdEn;    // Enable or flag view read at this edge
  assign wrData = avs_write && !avs_waitrequest && avs_address == ADR_DATA;
  assign enOff  = avs_write && !avs_waitrequest && avs_address == ADR_IENCLR
                  && avs_writedata[2:0] == 3'h7;
  assign rdEn   = avs_read && !avs_waitrequest && (avs_address == ADR_FLAGS
                  || avs_address == ADR_IENSET || avs_address == ADR_IENCLR);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_done;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  AST_WAIT_ONE: assert property (s_req |=> s_done)
    else $error("Access not answered after one wait cycle");
  AST_IDLE_WAIT: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("Waitrequest dropped without a request");
  AST_TX_TAKE: assert property (txTake && !wrData |=> !txValid)
    else $error("Word still waiting after being taken");
  AST_TX_LOAD: assert property (wrData && !txTake |=>
    txValid && txWord == $past(avs_writedata[8:0]))
    else $error("Data write did not load the transmit word");
  AST_TX_CAUSE: assert property ($rose(txValid) |-> $past(wrData))
    else $error("Transmit word appeared without a data write");
  AST_IRQ_OFF: assert property (enOff |-> ##2 !irqReq [*2])
    else $error("Interrupt still raised with all enables cleared");
  AST_VIEW_HI: assert property (rdEn |-> avs_readdata[31:3] == 29'h0)
    else $error("Reserved enable or flag bits read nonzero");
  AST_WAIT_BACK: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("Waitrequest low for more than one cycle");
endmodule
bind ssd_regs ssd_regs_asserts CHK (.sys_clk(sys_clk), .resetn(resetn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .txTake(txTake), .txWord(txWord),
  .txValid(txValid), .irqReq(irqReq));
`default_nettype wire

/* ssd_link_model.sv */
// Purpose: Shift engine and far-side device stand-in
// Assumes: Host shifting; select idles high
// Notes:   Latency per word set by lat, prompt or slow
`timescale 1ns/10ps
`default_nettype none
module ssd_link_model
  import ssd_pkg::*;
(
  input  wire logic        sys_clk,     // Clock
  input  wire logic        resetn,      // Reset, low active
  input  wire logic [3:0]  lat,         // Cycles per shifting step
  input  wire logic [8:0]  txWord,      // Word offered
  input  wire logic        txValid,     // Word waiting
  output var ssd_rxin_type rxIn,        // Received character
  output var logic         txTake,      // Word taken
  output var logic         shiftDone,   // Shifter emptied
  output var logic         selectHigh   // Select line level
);
  logic [3:0] waitCnt;    // Cycles on the current step
  logic [8:0] lastTaken;  // Last word shifted out
  logic       busy;       // Word in the shifter
  initial rxIn = '0;
  initial selectHigh = 1'b1;
  //////////////////////////////
  // Take the word after lat cycles, report empty after lat more
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      {txTake, shiftDone, busy, waitCnt, lastTaken} <= '0;
    end
    else
    begin
      txTake <= 1'b0;
      shiftDone <= 1'b0;
      if (waitCnt != lat && (busy || (txValid && !txTake)))
        waitCnt <= waitCnt + 4'h1;
      else if (busy)
      begin
        shiftDone <= 1'b1;
        busy <= 1'b0;
        waitCnt <= 4'h0;
      end
      else if (txValid && !txTake)
      begin
        txTake <= 1'b1;
        lastTaken <= txWord;
        busy <= 1'b1;
        waitCnt <= 4'h0;
      end
    end
  // One character pulse; the data lines then show the inverse
  task automatic push(input logic [8:0] w, input logic ap = 1'b0);
    @(posedge sys_clk);
    rxIn <= '{1'b1, ap, w};
    @(posedge sys_clk);
    rxIn <= '{1'b0, 1'b0, ~w};
  endtask
  // Select line moved just after the next edge; idles high between frames
  task automatic sel(input logic v);
    @(posedge sys_clk);
    selectHigh <= v;
  endtask
endmodule
`default_nettype wire

/* ssd_regs_tb.sv */
// Purpose: Self-checking bench for the register block
// Assumes: 10 MHz clock, Avalon-MM master tasks
// Notes:   Reads queue their expectation; a monitor compares
`timescale 1ns/10ps
`default_nettype none
module ssd_regs_tb
  import ssd_pkg::*;
  ;
  logic sys_clk, resetn, avs_read, avs_write, avs_waitrequest, debugHalt;
  logic txTake, shiftDone, selectHigh, txValid, rateTick, irqReq, linkEnable, hostMode;
  logic [7:0] avs_address, b;
  logic [31:0] avs_writedata, avs_readdata, expQ[$], mskQ[$];
  logic [8:0] txWord, w[3];
  logic [3:0] lat;
  ssd_rxin_type rxIn;
  int fails, cmp_count, seed, n;
  ssd_regs DUT (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rxIn(rxIn), .txTake(txTake),
    .shiftDone(shiftDone), .selectHigh(selectHigh), .debugHalt(debugHalt),
    .txWord(txWord), .txValid(txValid), .rateTick(rateTick), .irqReq(irqReq),
    .linkEnable(linkEnable), .hostMode(hostMode));
  ssd_link_model PM (.sys_clk(sys_clk), .resetn(resetn), .lat(lat), .txWord(txWord),
    .txValid(txValid), .rxIn(rxIn), .txTake(txTake), .shiftDone(shiftDone),
    .selectHigh(selectHigh));
  //////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("Compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Request held until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m);
    @(posedge sys_clk);
    {avs_read, avs_write, avs_address, avs_writedata} <= {!wr, wr, a, d};
    if (!wr)
    begin
      expQ.push_back(e);
      mskQ.push_back(m);
    end
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    {avs_read, avs_write} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 32'h0, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    acc(1'b0, a, 32'h0, e, m);
  endtask
  task automatic ticks(output int c);
    c = 0;
    repeat (20) @(posedge sys_clk) c += (rateTick === 1'b1);
  endtask
  // Read data compared with the oldest queued note
  always @(posedge sys_clk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && expQ.size() > 0)
      chk(avs_readdata & mskQ.pop_front(), expQ.pop_front());
  initial
  begin
    #(20000 * 100);
    fails++;
    give_verdict;
  end
  initial
  begin
    {seed, fails, cmp_count, resetn, avs_read, avs_write} = {32'h498E, 67'h0};
    {avs_address, avs_writedata, debugHalt, lat} = {41'h0, 4'h1};
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    foreach (w[i]) w[i] = 9'($random(seed));
    b = 8'h03 + 8'($random(seed) & 3);
    rd(ADR_DBG, 32'h0, 32'hFF);
    rd(ADR_IENSET, 32'h0, 32'hFF);
    rd(ADR_STATUS, 32'h0, 32'hFFFF);
    rd(ADR_ADDR, 32'h0, 32'hFFFFFFFF);
    wr(ADR_BAUD, {24'h0, b});
    wr(ADR_ADDR, 32'hFFA5FF5A);
    rd(ADR_ADDR, 32'h00A5005A, 32'hFFFFFFFF);
    wr(ADR_DBG, 32'h1);
    wr(ADR_CTRL, 32'h00020103);
    rd(ADR_STATUS, 32'h8000, 32'h8000);
    repeat (5) @(posedge sys_clk);
    rd(ADR_STATUS, 32'h0, 32'h8000);
    wr(ADR_BAUD, 32'h0);
    wr(ADR_ADDR, 32'h0);
    rd(ADR_BAUD, {24'h0, b}, 32'hFF);
    rd(ADR_ADDR, 32'h00A5005A, 32'hFFFFFFFF);
    @(posedge sys_clk iff rateTick === 1'b1);
    n = 0;
    do @(posedge sys_clk) n++; while (rateTick !== 1'b1);
    chk(n, b + 1);
    debugHalt <= 1'b1;
    @(posedge sys_clk);
    ticks(n);
    chk(n, 0);
    wr(ADR_DBG, 32'h0);
    ticks(n);
    chk(n != 0, 1);
    debugHalt <= 1'b0;
    wr(ADR_IENSET, 32'h7);
    rd(ADR_IENCLR, 32'h7, 32'h7);
    chk(irqReq, 1);
    wr(ADR_IENCLR, 32'h1);
    wr(ADR_IENSET, 32'h0);
    rd(ADR_IENSET, 32'h6, 32'h7);
    chk(irqReq, 0);
    wr(ADR_IENCLR, 32'h7);
    PM.push(w[0]);
    PM.push(w[1]);
    rd(ADR_FLAGS, 32'h4, 32'h4);
    rd(ADR_DATA, {23'h0, w[0]}, 32'h1FF);
    rd(ADR_DATA, {23'h0, w[1]}, 32'h1FF);
    rd(ADR_FLAGS, 32'h0, 32'h4);
    for (n = 0; n < 3; n++) PM.push(w[n]);
    rd(ADR_STATUS, 32'h4, 32'h4);
    wr(ADR_STATUS, 32'h0);
    rd(ADR_STATUS, 32'h4, 32'h4);
    wr(ADR_CTRL, 32'h00000103);
    rd(ADR_STATUS, 32'h0, 32'h4);
    rd(ADR_FLAGS, 32'h0, 32'h4);
    wr(ADR_CTRL, 32'h00020103);
    repeat (4) @(posedge sys_clk);
    for (n = 0; n < 3; n++) PM.push(w[n]);
    wr(ADR_STATUS, 32'h4);
    rd(ADR_STATUS, 32'h0, 32'h4);
    rd(ADR_DATA, {23'h0, w[0]}, 32'h1FF);
    rd(ADR_DATA, {23'h0, w[1]}, 32'h1FF);
    PM.push(9'h1FF);
    rd(ADR_DATA, 32'h0, 32'h1FF);
    lat <= 4'h6;
    wr(ADR_DATA, {23'h0, w[2]});
    rd(ADR_FLAGS, 32'h0, 32'h1);
    @(posedge sys_clk iff shiftDone === 1'b1);
    chk(PM.lastTaken, w[2]);
    rd(ADR_FLAGS, 32'h3, 32'h3);
    wr(ADR_FLAGS, 32'h1);
    rd(ADR_FLAGS, 32'h3, 32'h3);
    wr(ADR_FLAGS, 32'h2);
    rd(ADR_FLAGS, 32'h1, 32'h3);
    wr(ADR_CTRL, 32'h00020105);
    PM.sel(1'b0);
    chk({hostMode, linkEnable}, 2'b01);
    PM.push(9'h05A, 1'b1);
    PM.push(w[0]);
    PM.sel(1'b1);
    rd(ADR_FLAGS, 32'h6, 32'h6);
    rd(ADR_DATA, 32'h05A, 32'h1FF);
    rd(ADR_DATA, {23'h0, w[0]}, 32'h1FF);
    wr(ADR_FLAGS, 32'h2);
    PM.sel(1'b0);
    PM.push(9'h000, 1'b1);
    PM.push(w[1]);
    PM.sel(1'b1);
    rd(ADR_FLAGS, 32'h0, 32'h6);
    @(posedge sys_clk);
    chk(expQ.size(), 0);
    give_verdict;
  end
endmodule
`default_nettype wire
